/* File: inc/fsvi_pkg.sv */
// Shared constants for the four-source vectored interrupt controller
package fsvi_pkg;

    // Program counter width for a 4K-word program memory
    localparam int FSVI_PC_W = 12;
    // Return stack depth
    localparam int FSVI_STACK_DEPTH = 6;
    // Number of endpoint buffers with their own access flag
    localparam int FSVI_EP_NUM = 4;
    // Last value of the two-bit phase counter, which wraps every four clocks
    localparam logic [1:0] FSVI_PHASE_LAST = 2'h3;

    // Interrupt vectors
    localparam logic [FSVI_PC_W-1:0] FSVI_VEC_LINK = 12'h004;
    localparam logic [FSVI_PC_W-1:0] FSVI_VEC_EXT = 12'h008;
    localparam logic [FSVI_PC_W-1:0] FSVI_VEC_OVF = 12'h00c;
    localparam logic [FSVI_PC_W-1:0] FSVI_VEC_SER = 12'h010;

    // Register byte addresses
    localparam logic [7:0] FSVI_ADDR_CTRL1 = 8'h00;
    localparam logic [7:0] FSVI_ADDR_CTRL2 = 8'h04;
    localparam logic [7:0] FSVI_ADDR_EPACC = 8'h08;
    localparam logic [7:0] FSVI_ADDR_LINKC = 8'h0c;
    localparam logic [7:0] FSVI_ADDR_PINC = 8'h10;
    localparam logic [7:0] FSVI_ADDR_STAT = 8'h14;

    // Field positions in irq_control_first
    localparam int FSVI_B_GLOBAL = 0;
    localparam int FSVI_B_LINK_EN = 1;
    localparam int FSVI_B_EXT_EN = 2;
    localparam int FSVI_B_OVF_EN = 3;
    localparam int FSVI_B_LINK_FLAG = 4;
    localparam int FSVI_B_EXT_FLAG = 5;
    localparam int FSVI_B_OVF_FLAG = 6;
    // Field positions in irq_control_second
    localparam int FSVI_B_SER_EN = 0;
    localparam int FSVI_B_SER_FLAG = 4;
    // Field positions in link_control_reg
    localparam int FSVI_B_SUSPEND = 0;
    localparam int FSVI_B_BUSRST = 1;
    localparam int FSVI_B_RESUME = 3;
    // Field positions in pin configuration register
    localparam int FSVI_B_PULLUP = 0;
    localparam int FSVI_B_DIR6 = 1;

    // Reset values
    localparam logic [7:0] FSVI_RST_CTRL = 8'h00;
    localparam logic [7:0] FSVI_RST_LINKC = 8'h00;
    localparam logic [1:0] FSVI_RST_PINC = 2'h2;

endpackage

/* File: test/fsvi_core_model.sv */
// Core and event source model facing the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module fsvi_core_model
    import fsvi_pkg::*;
#(
    parameter logic [FSVI_PC_W-1:0] RET_PC = 12'h123
)
(
    input wire logic clk_in,
    output logic [11:0] evt_out,
    output logic [1:0] level_out,
    output logic [FSVI_PC_W-1:0] next_pc_out
);
    // Event and core command strobes, one cycle each
    logic [11:0] evt_r;
    // Pin six level in bit 0, power-down level in bit 1
    logic [1:0] level_r;
    initial
    begin
        evt_r = 12'h000;
        level_r = 2'h1;
    end
    assign evt_out = evt_r;
    assign level_out = level_r;
    // Fixed return address so every pop is predictable
    assign next_pc_out = RET_PC;
    // Raise strobes for one clock; the leading edge keeps calls apart
    task pulse(input logic [11:0] m);
        @(posedge clk_in);
        evt_r <= m;
        @(posedge clk_in);
        evt_r <= 12'h000;
    endtask
    // Change pin or power-down level just after an edge
    task level(input logic [1:0] v);
        @(posedge clk_in);
        level_r <= v;
    endtask
endmodule
`default_nettype wire

/* File: test/fsvi_ctrl_bench.sv */
// Self-checking bench for the vectored interrupt controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin failures++; \
    $display("BAD at %0t got %h expected %h", $time, (a), (b)); end end
module fsvi_ctrl_bench
    import fsvi_pkg::*;
;
    // Event strobe positions in the model's vector
    localparam logic [11:0] ev_ovf = 12'h001;
    localparam logic [11:0] ev_ser = 12'h002;
    localparam logic [11:0] ev_sus = 12'h004;
    localparam logic [11:0] ev_res = 12'h008;
    localparam logic [11:0] ev_brst = 12'h010;
    localparam logic [11:0] ev_ep2 = 12'h080;
    localparam logic [11:0] ev_call = 12'h200;
    localparam logic [11:0] ev_ret = 12'h400;
    localparam logic [11:0] ev_reti = 12'h800;
    localparam logic [11:0] ret_pc = 12'h123;
    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic hsel_in, hwrite_in;
    logic [1:0] htrans_in;
    logic [31:0] haddr_in, hwdata_in, rdat;
    wire logic [31:0] hrdata;
    wire logic hready, hresp, take, load, wake, phase, pull, dir, full;
    wire logic [11:0] evt, npc, pcv;
    wire logic [1:0] lvl;
    int failures = 0, n_compared = 0, n_take = 0, n_load = 0, n_wake = 0;
    int n_phase = 0;
    int exp_take = 0, exp_load = 0, i, tmp;
    logic [11:0] take_pc, ret_pc_seen;
    logic [11:0] vecs [4] = '{FSVI_VEC_LINK, FSVI_VEC_EXT, FSVI_VEC_OVF,
        FSVI_VEC_SER};
    // Clock of 10 ns period
    initial
    begin
        forever #5 clk_in = ~clk_in;
    end
    fsvi_core_model #(.RET_PC(ret_pc)) core (.clk_in(clk_in),
        .evt_out(evt), .level_out(lvl), .next_pc_out(npc));
    fsvi_ctrl dut (.clk_in(clk_in), .resetn_in(resetn_in),
        .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in),
        .hwrite_in(hwrite_in), .hsize_in(3'h2), .hwdata_in(hwdata_in),
        .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
        .hresp_out(hresp), .port_a_pin6_in(lvl[0]),
        .overflow_evt_in(evt[0]), .serial_done_in(evt[1]),
        .ep_access_in(evt[8:5]), .suspend_evt_in(evt[2]),
        .resume_evt_in(evt[3]), .bus_reset_evt_in(evt[4]),
        .next_pc_in(npc), .call_in(evt[9]), .ret_in(evt[10]),
        .reti_in(evt[11]), .power_down_in(lvl[1]), .irq_take_out(take),
        .pc_load_out(load), .pc_value_out(pcv), .wake_out(wake),
        .phase_two_pulse_out(phase), .pin6_pullup_out(pull),
        .pin6_input_out(dir), .stack_full_out(full));
    // Count one-cycle answers and keep the value each one carried
    always @(posedge clk_in)
    begin
        if (take === 1'b1)
        begin
            n_take++;
            take_pc = pcv;
        end
        else if (load === 1'b1)
            ret_pc_seen = pcv;
        if (load === 1'b1)
            n_load++;
        if (wake === 1'b1)
            n_wake++;
        if (phase === 1'b1)
            n_phase++;
    end
    // Print counts and the verdict, then stop
    task finish_test;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Bounded wait until a counter reaches its target
    task automatic wait_ge(ref int c, input int tgt);
        int k;
        k = 0;
        while (c < tgt && k < 60)
        begin
            @(posedge clk_in);
            k++;
        end
        if (c < tgt)
        begin
            failures++;
            $display("BAD at %0t got %h expected %h", $time, c, tgt);
            finish_test();
        end
    endtask
    // One AHB-Lite single word transfer, waiting on hready each phase
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] wd);
        int k;
        hsel_in <= 1'b1;
        htrans_in <= 2'h2;
        haddr_in <= {24'h0, a};
        hwrite_in <= w;
        k = 0;
        do begin @(posedge clk_in); k++; end while (hready !== 1'b1 && k < 50);
        htrans_in <= 2'h0;
        hwdata_in <= wd;
        do begin @(posedge clk_in); k++; end while (hready !== 1'b1 && k < 99);
        rdat = hrdata;
        tmp = k;
        wait_ge(tmp, 0);
        if (k >= 99)
            wait_ge(tmp, 999);
    endtask
    // Register read with comparison
    task rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK(rdat, e)
    endtask
    // Wait for an acknowledge and check its vector
    task wtake(input logic [11:0] v);
        exp_take++;
        exp_load++;
        wait_ge(n_take, exp_take);
        `CHK(take_pc, v)
    endtask
    // Wait for a return load and check the popped address
    task wload;
        exp_load++;
        wait_ge(n_load, exp_load);
        `CHK(ret_pc_seen, ret_pc)
    endtask
    // Asynchronous reset pulse in mid-run
    task rst;
        @(posedge clk_in);
        resetn_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        resetn_in <= 1'b1;
    endtask
    // Main sequence
    initial
    begin
        hsel_in = 1'b0;
        hwrite_in = 1'b0;
        htrans_in = 2'h0;
        haddr_in = 32'h0;
        hwdata_in = 32'h0;
        repeat (5) @(posedge clk_in);
        resetn_in <= 1'b1;
        rd(FSVI_ADDR_CTRL1, 32'h0);
        rd(FSVI_ADDR_PINC, 32'h2);
        rd(8'h18, 32'h0);
        `CHK(hresp, 1'b0)
        // Any eight cycles hold exactly two phase pulses
        tmp = n_phase;
        repeat (8) @(posedge clk_in);
        `CHK(n_phase - tmp, 2)
        $display("reset values test done");
        bus(1'b1, FSVI_ADDR_PINC, 32'h3);
        bus(1'b1, FSVI_ADDR_CTRL1, 32'h0e);
        bus(1'b1, FSVI_ADDR_CTRL2, 32'h01);
        core.level(2'h0);
        core.pulse(ev_sus | ev_ovf | ev_ser);
        repeat (12) @(posedge clk_in);
        `CHK(n_take, exp_take)
        `CHK({pull, dir}, 2'h3)
        rd(FSVI_ADDR_CTRL1, 32'h7e);
        rd(FSVI_ADDR_CTRL2, 32'h11);
        rd(FSVI_ADDR_LINKC, 32'h01);
        core.level(2'h1);
        bus(1'b1, FSVI_ADDR_CTRL1, 32'h7f);
        for (i = 0; i < 4; i++)
        begin
            wtake(vecs[i]);
            core.pulse(ev_reti);
            wload();
        end
        rd(FSVI_ADDR_CTRL1, 32'h0f);
        $display("priority test done");
        rst();
        for (i = 0; i < 6; i++)
            core.pulse(ev_call);
        rd(FSVI_ADDR_STAT, 32'h16);
        `CHK(full, 1'b1)
        bus(1'b1, FSVI_ADDR_CTRL1, 32'h09);
        core.pulse(ev_ovf);
        repeat (12) @(posedge clk_in);
        `CHK(n_take, exp_take)
        rd(FSVI_ADDR_CTRL1, 32'h49);
        core.pulse(ev_ret);
        wload();
        wtake(FSVI_VEC_OVF);
        $display("stack full test done");
        rst();
        bus(1'b1, FSVI_ADDR_CTRL1, 32'h0b);
        `CHK(full, 1'b0)
        core.pulse(ev_ovf);
        wtake(FSVI_VEC_OVF);
        bus(1'b1, FSVI_ADDR_CTRL1, 32'h03);
        core.pulse(ev_ep2);
        wtake(FSVI_VEC_LINK);
        rd(FSVI_ADDR_EPACC, 32'h4);
        bus(1'b1, FSVI_ADDR_EPACC, 32'h0);
        rd(FSVI_ADDR_EPACC, 32'h0);
        core.pulse(ev_res | ev_brst);
        repeat (4) @(posedge clk_in);
        rd(FSVI_ADDR_LINKC, 32'h0a);
        rd(FSVI_ADDR_CTRL1, 32'h12);
        $display("nesting test done");
        bus(1'b1, FSVI_ADDR_CTRL1, 32'h0);
        // Pin falls with its enable clear: no flag and no extra wake
        core.level(2'h2);
        tmp = n_wake + 1;
        core.pulse(ev_ovf);
        wait_ge(n_wake, tmp);
        `CHK(n_wake, tmp)
        rd(FSVI_ADDR_CTRL1, 32'h40);
        $display("wake test done");
        finish_test();
    end
endmodule
`default_nettype wire

/* File: verilog/fsvi_ctrl.sv */
// Vectored interrupt controller with AHB-Lite register access
//
// Design decisions made here: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module fsvi_ctrl
    import fsvi_pkg::*;
#(
    parameter int EP_NUM = FSVI_EP_NUM
)
(
    input wire logic clk_in,
    input wire logic resetn_in,
    // AHB-Lite slave
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    // Event sources: pin six as a level, the rest one-cycle pulses
    input wire logic port_a_pin6_in,
    input wire logic overflow_evt_in,
    input wire logic serial_done_in,
    input wire logic [EP_NUM-1:0] ep_access_in,
    input wire logic suspend_evt_in,
    input wire logic resume_evt_in,
    input wire logic bus_reset_evt_in,
    // Core side
    input wire logic [FSVI_PC_W-1:0] next_pc_in,
    input wire logic call_in,
    input wire logic ret_in,
    input wire logic reti_in,
    input wire logic power_down_in,
    output logic irq_take_out,
    output logic pc_load_out,
    output logic [FSVI_PC_W-1:0] pc_value_out,
    output logic wake_out,
    output logic phase_two_pulse_out,
    output logic pin6_pullup_out,
    output logic pin6_input_out,
    output logic stack_full_out
);
    localparam int SP_W = $clog2(FSVI_STACK_DEPTH+1);

    // Bus capture of a pending write
    logic wr_pend_r;
    logic [7:0] wr_addr_r;
    logic [31:0] rdata_nxt;
    logic [31:0] hrdata_r;
    // Control and flags
    logic global_r;
    logic link_en_r;
    logic ext_en_r;
    logic ovf_en_r;
    logic ser_en_r;
    logic link_flag_r;
    logic ext_flag_r;
    logic ovf_flag_r;
    logic ser_flag_r;
    logic [EP_NUM-1:0] ep_flag_r;
    logic suspend_r;
    logic resume_r;
    logic busrst_r;
    logic pullup_r;
    logic dir6_r;
    // Pin synchroniser and edge history
    logic pin_s1_r;
    logic pin_s2_r;
    logic pin_s3_r;
    logic ext_evt;
    logic link_evt;
    // Phase divider
    logic [1:0] phase_cnt_r;
    logic phase_en;
    logic phase_r;
    // Arbitration
    logic link_win;
    logic ext_win;
    logic ovf_win;
    logic ser_win;
    logic any_win;
    logic take;
    logic [FSVI_PC_W-1:0] vector;
    // Stack
    logic stk_full;
    logic stk_empty;
    logic [FSVI_PC_W-1:0] stk_top;
    logic [SP_W-1:0] stk_level;
    logic pop;
    logic push;
    // Output registers
    logic take_r;
    logic pc_load_r;
    logic [FSVI_PC_W-1:0] pc_value_r;
    logic wake_r;
    logic stack_full_r;
    logic wr_ctrl1;
    logic wr_ctrl2;

    // Address phase: latch writes, prepare read data
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            hrdata_r <= 32'h0000_0000;
        end
        else if (hready_in)
        begin
            wr_pend_r <= hsel_in && htrans_in[1] && hwrite_in;
            wr_addr_r <= haddr_in[7:0];
            hrdata_r <= rdata_nxt;
        end
    end

    // Read decode, unmapped addresses read zero
    always_comb
    begin
        rdata_nxt = 32'h0000_0000;
        if (!(hsel_in && htrans_in[1] && !hwrite_in))
            rdata_nxt = 32'h0000_0000;
        else if (haddr_in[7:0] == FSVI_ADDR_CTRL1)
            rdata_nxt = {25'h0, ovf_flag_r, ext_flag_r, link_flag_r,
                         ovf_en_r, ext_en_r, link_en_r, global_r};
        else if (haddr_in[7:0] == FSVI_ADDR_CTRL2)
            rdata_nxt = {27'h0, ser_flag_r, 3'h0, ser_en_r};
        else if (haddr_in[7:0] == FSVI_ADDR_EPACC)
            rdata_nxt = 32'(ep_flag_r);
        else if (haddr_in[7:0] == FSVI_ADDR_LINKC)
            rdata_nxt = {28'h0, resume_r, 1'b0, busrst_r, suspend_r};
        else if (haddr_in[7:0] == FSVI_ADDR_PINC)
            rdata_nxt = {30'h0, dir6_r, pullup_r};
        else if (haddr_in[7:0] == FSVI_ADDR_STAT)
            rdata_nxt = {27'h0, stk_full, 1'b0, stk_level};
        else
            rdata_nxt = 32'h0000_0000;
    end

    assign wr_ctrl1 = wr_pend_r && (wr_addr_r == FSVI_ADDR_CTRL1);
    assign wr_ctrl2 = wr_pend_r && (wr_addr_r == FSVI_ADDR_CTRL2);

    // Pin synchroniser, stage one feeds only stage two
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            pin_s1_r <= 1'b1;
            pin_s2_r <= 1'b1;
            pin_s3_r <= 1'b1;
        end
        else
        begin
            pin_s1_r <= port_a_pin6_in;
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
        end
    end

    // Falling edge counts only in interrupt mode
    assign ext_evt = ext_en_r && pin_s3_r && !pin_s2_r;
    // Any of the four link events
    assign link_evt = (|ep_access_in) || suspend_evt_in ||
                      resume_evt_in || bus_reset_evt_in;

    // Phase divider; the pulse is a flop so the output pin is glitch free
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            phase_cnt_r <= 2'h0;
            phase_r <= 1'b0;
        end
        else
        begin
            phase_cnt_r <= phase_cnt_r + 2'h1;
            // High while the counter sits at its last value
            phase_r <= (phase_cnt_r == FSVI_PHASE_LAST - 2'h1);
        end
    end
    assign phase_en = phase_r;

    // Priority winners from latched enabled flags
    assign link_win = link_flag_r && link_en_r;
    assign ext_win = !link_win && ext_flag_r && ext_en_r;
    assign ovf_win = !link_win && !ext_win && ovf_flag_r && ovf_en_r;
    assign ser_win = !link_win && !ext_win && !ovf_win &&
                     ser_flag_r && ser_en_r;
    assign any_win = link_win || ext_win || ovf_win || ser_win;
    // Acknowledge only on a phase pulse, enabled, stack has room
    assign take = phase_en && global_r && any_win && !stk_full &&
                  !reti_in && !ret_in && !call_in;

    // Vector of the winning source
    always_comb
    begin
        if (link_win)
            vector = FSVI_VEC_LINK;
        else if (ext_win)
            vector = FSVI_VEC_EXT;
        else if (ovf_win)
            vector = FSVI_VEC_OVF;
        else
            vector = FSVI_VEC_SER;
    end

    assign pop = reti_in || ret_in;
    assign push = take || (call_in && !pop);

    // Enables and global enable
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            global_r <= 1'b0;
            link_en_r <= 1'b0;
            ext_en_r <= 1'b0;
            ovf_en_r <= 1'b0;
            ser_en_r <= 1'b0;
        end
        else
        begin
            if (wr_ctrl1)
            begin
                link_en_r <= hwdata_in[FSVI_B_LINK_EN];
                ext_en_r <= hwdata_in[FSVI_B_EXT_EN];
                ovf_en_r <= hwdata_in[FSVI_B_OVF_EN];
            end
            if (wr_ctrl2)
                ser_en_r <= hwdata_in[FSVI_B_SER_EN];
            if (take)
                global_r <= 1'b0;
            else if (reti_in && !stk_empty)
                global_r <= 1'b1;
            else if (wr_ctrl1)
                global_r <= hwdata_in[FSVI_B_GLOBAL];
        end
    end

    // Request flags: event set beats any clear
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            link_flag_r <= 1'b0;
            ext_flag_r <= 1'b0;
            ovf_flag_r <= 1'b0;
            ser_flag_r <= 1'b0;
        end
        else
        begin
            // Latching ignores global enable
            link_flag_r <= link_evt || ((wr_ctrl1 ?
                hwdata_in[FSVI_B_LINK_FLAG] : link_flag_r) &&
                !(take && link_win));
            ext_flag_r <= ext_evt || ((wr_ctrl1 ?
                hwdata_in[FSVI_B_EXT_FLAG] : ext_flag_r) &&
                !(take && ext_win));
            ovf_flag_r <= overflow_evt_in || ((wr_ctrl1 ?
                hwdata_in[FSVI_B_OVF_FLAG] : ovf_flag_r) &&
                !(take && ovf_win));
            ser_flag_r <= serial_done_in || ((wr_ctrl2 ?
                hwdata_in[FSVI_B_SER_FLAG] : ser_flag_r) &&
                !(take && ser_win));
        end
    end

    // Link status: endpoint, suspend, resume and reset flags
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            ep_flag_r <= '0;
            suspend_r <= FSVI_RST_LINKC[FSVI_B_SUSPEND];
            resume_r <= FSVI_RST_LINKC[FSVI_B_RESUME];
            busrst_r <= FSVI_RST_LINKC[FSVI_B_BUSRST];
        end
        else
        begin
            ep_flag_r <= ep_access_in | ((wr_pend_r &&
                wr_addr_r == FSVI_ADDR_EPACC) ?
                hwdata_in[EP_NUM-1:0] : ep_flag_r);
            if (wr_pend_r && wr_addr_r == FSVI_ADDR_LINKC)
            begin
                suspend_r <= suspend_evt_in || hwdata_in[FSVI_B_SUSPEND];
                resume_r <= resume_evt_in || hwdata_in[FSVI_B_RESUME];
                busrst_r <= bus_reset_evt_in || hwdata_in[FSVI_B_BUSRST];
            end
            else
            begin
                suspend_r <= suspend_r || suspend_evt_in;
                resume_r <= resume_r || resume_evt_in;
                busrst_r <= busrst_r || bus_reset_evt_in;
            end
        end
    end

    // Pin configuration; pull-high and direction change only on a bus write
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            pullup_r <= FSVI_RST_PINC[FSVI_B_PULLUP];
            dir6_r <= FSVI_RST_PINC[FSVI_B_DIR6];
        end
        else if (wr_pend_r && wr_addr_r == FSVI_ADDR_PINC)
        begin
            pullup_r <= hwdata_in[FSVI_B_PULLUP];
            dir6_r <= hwdata_in[FSVI_B_DIR6];
        end
    end

    // Return address stack
    fsvi_stack #(
        .DEPTH(FSVI_STACK_DEPTH),
        .WIDTH(FSVI_PC_W)
    ) u_stack (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .push_in(push),
        .push_data_in(next_pc_in),
        .pop_in(pop),
        .top_out(stk_top),
        .full_out(stk_full),
        .empty_out(stk_empty),
        .level_out(stk_level)
    );

    // Core-facing outputs: vector on take, saved PC on return
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            take_r <= 1'b0;
            pc_load_r <= 1'b0;
            pc_value_r <= '0;
            wake_r <= 1'b0;
            stack_full_r <= 1'b0;
        end
        else
        begin
            take_r <= take;
            pc_load_r <= take || (pop && !stk_empty);
            if (take)
                pc_value_r <= vector;
            else if (pop && !stk_empty)
                pc_value_r <= stk_top;
            // Overflow wakes even when its enable is clear
            wake_r <= power_down_in && (overflow_evt_in ||
                (ext_evt) || (link_evt && link_en_r) ||
                (serial_done_in && ser_en_r));
            // Status copy of the stack limit for the core
            stack_full_r <= stk_full;
        end
    end

    assign hrdata_out = hrdata_r;
    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;
    assign irq_take_out = take_r;
    assign pc_load_out = pc_load_r;
    assign pc_value_out = pc_value_r;
    assign wake_out = wake_r;
    assign phase_two_pulse_out = phase_r;
    assign pin6_pullup_out = pullup_r;
    assign pin6_input_out = dir6_r;
    assign stack_full_out = stack_full_r;

    // Checks
    property p_global_gate;
        @(posedge clk_in) disable iff (!resetn_in)
        take_r |-> $past(global_r) && !global_r;
    endproperty
    a_global_gate: assert property (p_global_gate)
        else $error("Interrupt taken without global enable");

    property p_stack_room;
        @(posedge clk_in) disable iff (!resetn_in)
        take_r |-> !$past(stk_full);
    endproperty
    a_stack_room: assert property (p_stack_room)
        else $error("Interrupt taken with full stack");

    property p_phase;
        @(posedge clk_in) disable iff (!resetn_in)
        take_r |-> ##3 phase_en;
    endproperty
    a_phase: assert property (p_phase)
        else $error("Interrupt taken off the phase pulse");

    property p_link_vec;
        @(posedge clk_in) disable iff (!resetn_in)
        (take && link_win) |=> pc_load_r && pc_value_r == 12'h004
            && link_flag_r == $past(link_evt);
    endproperty
    a_link_vec: assert property (p_link_vec)
        else $error("Link vector or flag wrong");

    property p_ext_edge;
        @(posedge clk_in) disable iff (!resetn_in)
        (ext_en_r && pin_s3_r && !pin_s2_r) |=> ext_flag_r;
    endproperty
    a_ext_edge: assert property (p_ext_edge)
        else $error("Pin edge did not set flag");

    property p_ovf_flag;
        @(posedge clk_in) disable iff (!resetn_in)
        overflow_evt_in |=> ovf_flag_r;
    endproperty
    a_ovf_flag: assert property (p_ovf_flag)
        else $error("Overflow did not set flag");

    property p_reti;
        @(posedge clk_in) disable iff (!resetn_in)
        (reti_in && !stk_empty) |=> pc_load_r && global_r
            && pc_value_r == $past(stk_top);
    endproperty
    a_reti: assert property (p_reti)
        else $error("Return did not restore PC and enable");

    property p_persist;
        @(posedge clk_in) disable iff (!resetn_in)
        (ser_flag_r && !take && !wr_ctrl2) |=> ser_flag_r;
    endproperty
    a_persist: assert property (p_persist)
        else $error("Serial flag lost");

    property p_wake;
        @(posedge clk_in) disable iff (!resetn_in)
        (power_down_in && overflow_evt_in) |=> wake_out;
    endproperty
    a_wake: assert property (p_wake)
        else $error("Overflow did not wake");

    property p_cov_take;
        @(posedge clk_in) disable iff (!resetn_in)
        take && ser_win;
    endproperty
    c_cov_take: cover property (p_cov_take);

    property p_cov_nest;
        @(posedge clk_in) disable iff (!resetn_in)
        take && stk_level != '0;
    endproperty
    c_cov_nest: cover property (p_cov_nest);

    property p_cov_full;
        @(posedge clk_in) disable iff (!resetn_in)
        phase_en && global_r && any_win && stk_full;
    endproperty
    c_cov_full: cover property (p_cov_full);
endmodule
`default_nettype wire

/* File: verilog/fsvi_stack.sv */
// Return address stack for the program counter
`timescale 1ns/1ps
`default_nettype none
module fsvi_stack
    import fsvi_pkg::*;
#(
    parameter int DEPTH = FSVI_STACK_DEPTH,
    parameter int WIDTH = FSVI_PC_W
)
(
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic push_in,
    input wire logic [WIDTH-1:0] push_data_in,
    input wire logic pop_in,
    output logic [WIDTH-1:0] top_out,
    output logic full_out,
    output logic empty_out,
    output logic [$clog2(DEPTH+1)-1:0] level_out
);
    localparam int SP_W = $clog2(DEPTH+1);
    // Saved return addresses
    logic [WIDTH-1:0] mem [DEPTH];
    // Number of stored entries
    logic [SP_W-1:0] sp_r;

    assign full_out = (sp_r == SP_W'(DEPTH));
    assign empty_out = (sp_r == '0);
    assign level_out = sp_r;
    assign top_out = empty_out ? '0 : mem[sp_r - SP_W'(1)];

    // Pointer moves; push into full or pop from empty is dropped
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            sp_r <= '0;
        else if (pop_in && !empty_out)
            sp_r <= sp_r - SP_W'(1);
        else if (push_in && !full_out)
            sp_r <= sp_r + SP_W'(1);
    end

    // Entry store, no reset needed
    always_ff @(posedge clk_in)
    begin
        if (push_in && !pop_in && !full_out)
            mem[sp_r] <= push_data_in;
    end
endmodule
`default_nettype wire
